// [common/sfe_pkg.sv]
package sfe_pkg;
	localparam int LANES = 4;
	localparam int EXC_W = 6;
	// exception bit positions
	localparam int EX_INV = 0;
	localparam int EX_DEN = 1;
	localparam int EX_DIV = 2;
	localparam int EX_OVF = 3;
	localparam int EX_UNF = 4;
	localparam int EX_INX = 5;
	localparam logic [EXC_W-1:0] PRE_SET  = 6'h07;
	localparam logic [EXC_W-1:0] POST_SET = 6'h38;
	// control/status word layout
	localparam int CS_FLAG_LSB = 0;
	localparam int CS_DAZ      = 6;
	localparam int CS_MASK_LSB = 7;
	localparam int CS_FTZ      = 13;
	localparam logic [EXC_W-1:0] MASK_RST = 6'h3F;
	// register byte offsets
	localparam logic [7:0] OFS_CS      = 8'h00;
	localparam logic [7:0] OFS_IRQ_ST  = 8'h04;
	localparam logic [7:0] OFS_IRQ_MSK = 8'h08;
	localparam logic [7:0] OFS_TRAP    = 8'h0C;
	// interrupt status bits
	localparam int IRQ_W     = 2;
	localparam int IRQ_TRAP  = 0;
	localparam int IRQ_MASKD = 1;
	localparam logic [7:0] TRAP_VECTOR = 8'h13;

	typedef struct packed {
		logic                           valid;
		logic                           intGate;
		logic [LANES-1:0]               laneEn;
		logic [LANES-1:0][EXC_W-1:0]    laneExc;
	} sfe_op_t;

	typedef struct packed {
		logic             valid;
		logic [7:0]       vector;
		logic [EXC_W-1:0] cause;
		logic             clearIf;
		logic             wbEn;
	} sfe_trap_t;

	typedef struct packed {
		logic ftz;
		logic daz;
	} sfe_mode_t;
endpackage

// [rtl/sfe_exc_unit.sv]
// Functional notes
// - an unmasked vector exception traps at the very instruction raising it.
// - a sticky flag already set with its mask clear never causes a trap.
// - exceptions are never deferred to a later floating-point instruction.
// - on an unmasked overflow/underflow/inexact trap the result is not written.
// - packed flags are the OR of the enabled lanes' flags, with no lane recorded.
// - unmasked exceptions are dispatched through vector 19.
// - with flush-to-zero and denormals-are-zero off, results are standard.
// - each of the six exceptions has its own mask bit for trapping.
// - exceptions are seen correctly with no software synchronisation.
// - delivery through an interrupt gate clears the interrupt enable flag.
// - a masked exception gives the default result, sets its flag, no trap.
// - invalid, divide and denormal are found before, the rest after, the op.
module sfe_exc_unit
	import sfe_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire sfe_op_t     op,
	output sfe_trap_t        trapOut,
	output sfe_mode_t        modeOut,
	output logic             irq
);
	////////////////////////////////////////////////////////////////////////
	logic [EXC_W-1:0] flags_reg;
	logic [EXC_W-1:0] flags_next;
	logic [EXC_W-1:0] mask_reg;
	logic [EXC_W-1:0] mask_next;
	logic [IRQ_W-1:0] irqSt_reg;
	logic [IRQ_W-1:0] irqSt_next;
	logic [IRQ_W-1:0] irqMsk_reg;
	logic [EXC_W-1:0] lastCause_reg;
	logic [15:0]      trapCnt_reg;
	logic [EXC_W-1:0] merged;
	logic [31:0]      rdMux;

	function automatic logic [31:0] cs_word(input logic [EXC_W-1:0] f,
		input logic [EXC_W-1:0] m, input sfe_mode_t md);
		logic [31:0] w;
		w = '0;
		w[CS_FLAG_LSB +: EXC_W] = f;
		w[CS_MASK_LSB +: EXC_W] = m;
		w[CS_DAZ] = md.daz;
		w[CS_FTZ] = md.ftz;
		return w;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// apb decode
	wire apbAcc  = psel & penable;
	wire hitCs   = (paddr == OFS_CS);
	wire hitIst  = (paddr == OFS_IRQ_ST);
	wire hitImsk = (paddr == OFS_IRQ_MSK);
	wire hitTrap = (paddr == OFS_TRAP);
	wire hitAny  = hitCs | hitIst | hitImsk | hitTrap;
	wire commit  = apbAcc & pready;
	wire wrCs    = commit & pwrite & hitCs;
	wire wrIst   = commit & pwrite & hitIst;
	wire wrImsk  = commit & pwrite & hitImsk;

	assign rdMux = hitCs   ? cs_word(flags_reg, mask_reg, modeOut) :
	               hitIst  ? {{(32-IRQ_W){1'b0}}, irqSt_reg} :
	               hitImsk ? {{(32-IRQ_W){1'b0}}, irqMsk_reg} :
	               hitTrap ? {trapCnt_reg, TRAP_VECTOR, 2'h0, lastCause_reg} :
	               32'h0000_0000;

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= apbAcc & ~pready;
			pslverr <= apbAcc & ~pready & ~hitAny;
			prdata  <= (apbAcc & ~pready & ~pwrite) ? rdMux : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// lane merge and exception classification
	sfe_lane_merge u_merge (
		.laneEn  (op.laneEn),
		.laneExc (op.laneExc),
		.merged  (merged)
	);

	wire [EXC_W-1:0] preExc   = merged & PRE_SET;
	wire [EXC_W-1:0] postExc  = merged & POST_SET;
	// an unmasked pre-computation fault stops the op before it computes
	wire             preFault = |(preExc & ~mask_reg);
	wire [EXC_W-1:0] raised   = op.valid ?
	                            (preFault ? preExc : preExc | postExc) :
	                            '0;
	// only this op's new conditions can trap, never sticky flags
	wire [EXC_W-1:0] unmasked = raised & ~mask_reg;
	wire             takeTrap = |unmasked;
	wire             maskedEv = op.valid & (|raised) & ~takeTrap;

	////////////////////////////////////////////////////////////////////////
	// control/status word; hardware set wins over software write
	assign flags_next = (wrCs ? pwdata[CS_FLAG_LSB +: EXC_W] : flags_reg)
	                    | raised;
	assign mask_next  = wrCs ? pwdata[CS_MASK_LSB +: EXC_W] : mask_reg;

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			flags_reg   <= '0;
			mask_reg    <= MASK_RST;
			modeOut.ftz <= 1'b0;
			modeOut.daz <= 1'b0;
		end
		else
		begin
			flags_reg <= flags_next;
			mask_reg  <= mask_next;
			if (wrCs)
			begin
				modeOut.ftz <= pwdata[CS_FTZ];
				modeOut.daz <= pwdata[CS_DAZ];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// trap delivery: registered one cycle after the op, never deferred
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			trapOut       <= '0;
			lastCause_reg <= '0;
			trapCnt_reg   <= 16'h0000;
		end
		else
		begin
			trapOut.valid   <= takeTrap;
			trapOut.vector  <= takeTrap ? TRAP_VECTOR : 8'h00;
			trapOut.cause   <= unmasked;
			trapOut.clearIf <= takeTrap & op.intGate;
			trapOut.wbEn    <= op.valid & ~takeTrap;
			if (takeTrap)
			begin
				lastCause_reg <= unmasked;
				trapCnt_reg   <= trapCnt_reg + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt status (write one to clear, set wins), mask, level output
	wire [IRQ_W-1:0] irqEv = {maskedEv, takeTrap};
	assign irqSt_next = (irqSt_reg & ~(wrIst ? pwdata[IRQ_W-1:0] : '0))
	                    | irqEv;

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			irqSt_reg  <= '0;
			irqMsk_reg <= '0;
			irq        <= 1'b0;
		end
		else
		begin
			irqSt_reg <= irqSt_next;
			if (wrImsk)
			begin
				irqMsk_reg <= pwdata[IRQ_W-1:0];
			end
			irq <= |(irqSt_next & (wrImsk ? pwdata[IRQ_W-1:0] : irqMsk_reg));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sequence s_unmaskedOp;
		op.valid && ((raised & ~mask_reg) != '0);
	endsequence

	sequence s_trapDelivered;
		trapOut.valid && trapOut.vector == 8'h13 && !trapOut.wbEn;
	endsequence

	property p_precise;
		s_unmaskedOp |=> s_trapDelivered;
	endproperty
	a_precise: assert property (p_precise)
		else $error("unmasked exception not trapped at its instruction");

	property p_noStickyTrap;
		!op.valid |=> !trapOut.valid;
	endproperty
	a_noStickyTrap: assert property (p_noStickyTrap)
		else $error("trap raised with no new condition");

	property p_noDefer;
		trapOut.valid |-> $past(op.valid);
	endproperty
	a_noDefer: assert property (p_noDefer)
		else $error("trap not tied to the previous instruction");

	property p_noResult;
		trapOut.valid |-> !trapOut.wbEn;
	endproperty
	a_noResult: assert property (p_noResult)
		else $error("result written on a trap");

	property p_laneOr;
		op.valid && !wrCs |=>
			flags_reg == ($past(flags_reg) | ($past(merged) &
			($past(preFault) ? PRE_SET : 6'h3F)));
	endproperty
	a_laneOr: assert property (p_laneOr)
		else $error("flags are not the OR of the lanes");

	property p_vector;
		trapOut.valid |-> trapOut.vector == 8'h13;
	endproperty
	a_vector: assert property (p_vector)
		else $error("trap vector is not 19");

	property p_ifClear;
		op.valid && op.intGate && takeTrap |=> trapOut.clearIf;
	endproperty
	a_ifClear: assert property (p_ifClear)
		else $error("interrupt gate did not clear interrupt enable");

	property p_masked;
		op.valid && raised != '0 && (raised & ~mask_reg) == '0
			|=> !trapOut.valid && trapOut.wbEn && irqSt_reg[IRQ_MASKD];
	endproperty
	a_masked: assert property (p_masked)
		else $error("masked exception mishandled");

	property p_preFirst;
		op.valid && preFault |=> (trapOut.cause & POST_SET) == '0;
	endproperty
	a_preFirst: assert property (p_preFirst)
		else $error("post-computation cause on a pre-computation fault");

	property p_sticky;
		!wrCs |=> (flags_reg & $past(flags_reg)) == $past(flags_reg);
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("sticky flag cleared without a write");

	property p_irqLevel;
		##1 irq == |($past(irqSt_next) & irqMsk_reg);
	endproperty
	a_irqLevel: assert property (p_irqLevel)
		else $error("interrupt level does not follow status and mask");

	sequence s_accessFirst;
		psel && penable && !pready;
	endsequence

	sequence s_answer;
		pready ##1 !pready;
	endsequence

	property p_apbAnswer;
		s_accessFirst |=> s_answer;
	endproperty
	a_apbAnswer: assert property (p_apbAnswer)
		else $error("bus answer not one cycle after the access edge");

	property p_apbErr;
		apbAcc && !pready && !hitAny |=> pslverr && pready;
	endproperty
	a_apbErr: assert property (p_apbErr)
		else $error("unmapped access without an error answer");

	property p_errOnlyAnswer;
		pslverr |-> pready;
	endproperty
	a_errOnlyAnswer: assert property (p_errOnlyAnswer)
		else $error("error flag outside the answer cycle");

	property p_rdIdle;
		!pready |-> prdata == 32'h0000_0000;
	endproperty
	a_rdIdle: assert property (p_rdIdle)
		else $error("read data outside the answer cycle");

	property p_noNewCond;
		op.valid && (merged & ~mask_reg) == '0 |=> !trapOut.valid;
	endproperty
	a_noNewCond: assert property (p_noNewCond)
		else $error("trap with no unmasked condition in the op");

	property p_maskedNoCause;
		op.valid |=> (trapOut.cause & $past(mask_reg)) == '0;
	endproperty
	a_maskedNoCause: assert property (p_maskedNoCause)
		else $error("masked condition reported as trap cause");

	property p_causeOnTrap;
		trapOut.valid |-> trapOut.cause != '0;
	endproperty
	a_causeOnTrap: assert property (p_causeOnTrap)
		else $error("trap without a cause");

	property p_clearOnTrap;
		trapOut.clearIf |-> trapOut.valid;
	endproperty
	a_clearOnTrap: assert property (p_clearOnTrap)
		else $error("interrupt enable cleared without a trap");

	property p_wbOnOp;
		trapOut.wbEn |-> $past(op.valid);
	endproperty
	a_wbOnOp: assert property (p_wbOnOp)
		else $error("write enable with no completing op");

	property p_vectorIdle;
		!trapOut.valid |-> trapOut.vector == 8'h00;
	endproperty
	a_vectorIdle: assert property (p_vectorIdle)
		else $error("vector shown with no trap");

	property p_flagSet;
		op.valid |=> (flags_reg & $past(raised)) == $past(raised);
	endproperty
	a_flagSet: assert property (p_flagSet)
		else $error("raised condition did not set its sticky flag");

	property p_trapStatus;
		op.valid && (merged & ~mask_reg) != '0 |=> irqSt_reg[IRQ_TRAP];
	endproperty
	a_trapStatus: assert property (p_trapStatus)
		else $error("unmasked condition did not set trap status");

	property p_trapCount;
		takeTrap |=> trapCnt_reg == $past(trapCnt_reg) + 16'h0001;
	endproperty
	a_trapCount: assert property (p_trapCount)
		else $error("trap counter did not advance");

	property p_modeHold;
		!wrCs |=> $stable(modeOut);
	endproperty
	a_modeHold: assert property (p_modeHold)
		else $error("mode bits changed without a write");
endmodule // sfe_exc_unit

// [rtl/sfe_lane_merge.sv]
module sfe_lane_merge
	import sfe_pkg::*;
(
	input  wire logic [LANES-1:0]            laneEn,
	input  wire logic [LANES-1:0][EXC_W-1:0] laneExc,
	output logic      [EXC_W-1:0]            merged
);
	always_comb
	begin
		merged = '0;
		for (int i = 0; i < LANES; i++)
		begin
			if (laneEn[i])
			begin
				merged = merged | laneExc[i];
			end
		end
	end
endmodule // sfe_lane_merge

// [verification/testbench.sv]
module testbench
	import sfe_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        mclk      = 1'b0;
	logic        rst_b     = 1'b0;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [7:0]  paddr     = 8'h00;
	logic [31:0] pwdata    = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	sfe_op_t     opIn      = '0;
	sfe_trap_t   trapOut;
	sfe_mode_t   modeOut;
	logic        irq;
	int          err_count = 0;
	int          n_checks  = 0;
	logic [5:0]  msk;

	always #20 mclk = ~mclk;

	sfe_exc_unit u_sfe_exc_unit (
		.mclk    (mclk),
		.rst_b   (rst_b),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.op      (opIn),
		.trapOut (trapOut),
		.modeOut (modeOut),
		.irq     (irq)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic results();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// one apb transfer; read data and error flag taken at the pready edge
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic expErr);
		int n;
		n = 0;
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1);
		chk("pready", 32'h1, pready);
		chk("wait cycles", 32'h2, n);
		if (!wr)
			chk("prdata", d, prdata);
		chk("pslverr", expErr, pslverr);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// one completing instruction; trap fields looked at in their one cycle
	task automatic sendOp(input logic g, input logic [3:0] en,
		input logic [23:0] exc, input logic [5:0] cause, input logic trap);
		@(posedge mclk);
		opIn <= '{valid: 1'b1, intGate: g, laneEn: en, laneExc: exc};
		@(posedge mclk);
		opIn.valid <= 1'b0;
		#1;
		chk("trap valid", trap, trapOut.valid);
		chk("trap vector", trap ? 32'h13 : 32'h0, trapOut.vector);
		chk("trap cause", cause, trapOut.cause);
		chk("trap clearIf", trap & g, trapOut.clearIf);
		chk("write enable", !trap, trapOut.wbEn);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		#200000;
		err_count++;
		results();
	end

	initial
	begin
		repeat (8) @(posedge mclk);
		rst_b <= 1'b1;
		apb(1'b0, OFS_CS, 32'h00001F80, 1'b0);
		apb(1'b0, OFS_IRQ_MSK, 32'h00000000, 1'b0);
		apb(1'b0, OFS_TRAP, 32'h00001300, 1'b0);
		apb(1'b0, 8'h10, 32'h00000000, 1'b1);
		apb(1'b1, 8'h14, 32'hFFFFFFFF, 1'b1);
		sendOp(1'b1, 4'hF, 24'h008000, 6'h00, 1'b0);
		apb(1'b0, OFS_CS, 32'h00001F88, 1'b0);
		apb(1'b0, OFS_IRQ_ST, 32'h00000002, 1'b0);
		chk("irq masked", 32'h0, irq);
		apb(1'b1, OFS_IRQ_ST, 32'h00000003, 1'b0);
		apb(1'b0, OFS_IRQ_ST, 32'h00000000, 1'b0);
		apb(1'b1, OFS_IRQ_MSK, 32'h00000001, 1'b0);
		apb(1'b1, OFS_CS, 32'h00001B80, 1'b0);
		apb(1'b0, OFS_CS, 32'h00001B80, 1'b0);
		sendOp(1'b1, 4'hF, 24'h008000, 6'h08, 1'b1);
		sendOp(1'b1, 4'hF, 24'h000000, 6'h00, 1'b0);
		apb(1'b0, OFS_IRQ_ST, 32'h00000001, 1'b0);
		chk("irq raised", 32'h1, irq);
		apb(1'b1, OFS_IRQ_ST, 32'h00000001, 1'b0);
		apb(1'b0, OFS_IRQ_ST, 32'h00000000, 1'b0);
		chk("irq cleared", 32'h0, irq);
		// lane 2 disabled: its invalid must not reach the flags
		sendOp(1'b0, 4'hB, 24'h801210, 6'h08, 1'b1);
		apb(1'b0, OFS_CS, 32'h00001BB8, 1'b0);
		for (int i = 0; i < 6; i++)
		begin
			msk = 6'h3F & ~(6'h01 << i);
			apb(1'b1, OFS_CS, {19'h0, msk, 7'h00}, 1'b0);
			sendOp(1'b0, 4'h1, 24'h1 << i, 6'h01 << i, 1'b1);
			apb(1'b0, OFS_CS, {19'h0, msk, 1'b0, 6'h01 << i}, 1'b0);
		end
		// invalid and overflow together: the early fault drops the late one
		apb(1'b1, OFS_CS, 32'h00001B00, 1'b0);
		sendOp(1'b0, 4'h1, 24'h000009, 6'h01, 1'b1);
		apb(1'b0, OFS_CS, 32'h00001B01, 1'b0);
		apb(1'b0, OFS_TRAP, 32'h00091301, 1'b0);
		apb(1'b1, OFS_CS, 32'h00003FC0, 1'b0);
		@(posedge mclk);
		#1;
		chk("mode", 32'h3, modeOut);
		apb(1'b1, OFS_CS, 32'h00001F80, 1'b0);
		@(posedge mclk);
		#1;
		chk("mode off", 32'h0, modeOut);
		// reset in mid-run with flags, modes and irq all up
		apb(1'b1, OFS_CS, 32'h00003FFF, 1'b0);
		@(posedge mclk);
		rst_b <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		#1;
		chk("mode reset", 32'h0, modeOut);
		chk("irq reset", 32'h0, irq);
		chk("trap reset", 32'h0, trapOut);
		apb(1'b0, OFS_CS, 32'h00001F80, 1'b0);
		apb(1'b0, OFS_IRQ_MSK, 32'h00000000, 1'b0);
		apb(1'b0, OFS_TRAP, 32'h00001300, 1'b0);
		// masked-exception interrupt source
		apb(1'b1, OFS_IRQ_MSK, 32'h00000002, 1'b0);
		sendOp(1'b0, 4'h1, 24'h000020, 6'h00, 1'b0);
		chk("irq masked event", 32'h1, irq);
		apb(1'b0, OFS_IRQ_ST, 32'h00000002, 1'b0);
		apb(1'b0, OFS_CS, 32'h00001FA0, 1'b0);
		results();
	end
endmodule // testbench
